// ---- oxcvr_mgmt.sv ----
// Transceiver control pins, fault latch and two-page serial management memory
`timescale 1ns/1ns
`include "oxcvr_regs.svh"

module oxcvr_mgmt (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        tx_rate_i,
  input  wire logic        rx_rate_i,
  input  wire logic        tx_disable_i,
  input  wire logic        laser_fault_i,
  input  wire logic        optical_input_lost_i,
  input  wire logic [15:0] mon_temp_i,
  input  wire logic [15:0] mon_vcc_i,
  input  wire logic [15:0] mon_bias_i,
  input  wire logic [15:0] mon_txpwr_i,
  input  wire logic [15:0] mon_rxpwr_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             tx_cdr_engage_o,
  output logic             rx_cdr_engage_o,
  output logic             laser_on_o,
  output logic             tx_fault_o,
  output logic             tx_path_reset_o,
  output logic             optical_input_lost_o
);
  import oxcvr_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic tx_rate_q;
  logic rx_rate_q;
  logic hw_dis_q;
  logic fault_q;
  logic los_q;
  logic scl_q;
  logic sda_q;

  oxcvr_pin_sync #(.RST_VAL(`OXCVR_PIN_LOW_RST)) u_sync_txr (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (tx_rate_i), .level_o (tx_rate_q));
  oxcvr_pin_sync #(.RST_VAL(`OXCVR_PIN_LOW_RST)) u_sync_rxr (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (rx_rate_i), .level_o (rx_rate_q));
  // Shutdown reads as asserted out of reset, as the pull-up would leave it
  oxcvr_pin_sync #(.RST_VAL(`OXCVR_HW_DIS_RST)) u_sync_dis (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (tx_disable_i), .level_o (hw_dis_q));
  oxcvr_pin_sync #(.RST_VAL(`OXCVR_PIN_LOW_RST)) u_sync_flt (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (laser_fault_i), .level_o (fault_q));
  oxcvr_pin_sync #(.RST_VAL(`OXCVR_PIN_LOW_RST)) u_sync_los (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (optical_input_lost_i), .level_o (los_q));
  oxcvr_pin_sync #(.RST_VAL(`OXCVR_IDLE_HIGH_RST)) u_sync_scl (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (scl_i), .level_o (scl_q));
  oxcvr_pin_sync #(.RST_VAL(`OXCVR_IDLE_HIGH_RST)) u_sync_sda (
    .ref_clk_i (ref_clk_i), .rstn_i (rstn_i), .pin_i (sda_i), .level_o (sda_q));

  // ---------------------------------------------------------------
  // Transmit control and fault latch
  // ---------------------------------------------------------------
  logic hw_dis_d_r;
  logic sw_dis_r;
  logic fault_r;
  logic dis_fall;

  assign dis_fall = hw_dis_d_r & ~hw_dis_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      hw_dis_d_r <= `OXCVR_HW_DIS_RST;
    end else begin
      hw_dis_d_r <= hw_dis_q;
    end
  end

  // A fault arriving in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      fault_r <= 1'b0;
    end else if (fault_q) begin
      fault_r <= 1'b1;
    end else if (dis_fall) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tx_cdr_engage_o      <= 1'b0;
      rx_cdr_engage_o      <= 1'b0;
      laser_on_o           <= 1'b0;
      tx_fault_o           <= 1'b0;
      tx_path_reset_o      <= 1'b0;
      optical_input_lost_o <= 1'b0;
    end else begin
      tx_cdr_engage_o      <= tx_rate_q;
      rx_cdr_engage_o      <= rx_rate_q;
      laser_on_o           <= ~(hw_dis_q | sw_dis_r | fault_r | fault_q);
      tx_fault_o           <= fault_r | fault_q;
      tx_path_reset_o      <= dis_fall;
      optical_input_lost_o <= los_q;
    end
  end

  chk_tx_cdr_rise: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $rose(tx_rate_q) |=> tx_cdr_engage_o) else $error("tx recovery not engaged");
  chk_rx_cdr_fall: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $fell(rx_rate_q) |=> !rx_cdr_engage_o) else $error("rx recovery not bypassed");
  chk_hw_shutdown: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    hw_dis_q |=> !laser_on_o) else $error("laser on while hw shutdown");
  chk_sw_shutdown: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sw_dis_r && !hw_dis_q |=> !laser_on_o) else $error("laser on while sw shutdown");
  chk_fault_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    fault_r && !dis_fall |=> fault_r ##1 tx_fault_o) else $error("fault latch lost");
  chk_path_reset: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    $fell(hw_dis_q) |=> tx_path_reset_o) else $error("no path reset on toggle");

  // ---------------------------------------------------------------
  // Serial bus conditions
  // ---------------------------------------------------------------
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      scl_d_r <= `OXCVR_IDLE_HIGH_RST;
      sda_d_r <= `OXCVR_IDLE_HIGH_RST;
    end else begin
      scl_d_r <= scl_q;
      sda_d_r <= sda_q;
    end
  end

  assign scl_rise  = scl_q & ~scl_d_r;
  assign scl_fall  = ~scl_q & scl_d_r;
  assign bus_start = scl_q & scl_d_r & sda_d_r & ~sda_q;
  assign bus_stop  = scl_q & scl_d_r & ~sda_d_r & sda_q;

  // ---------------------------------------------------------------
  // Memory pages
  // ---------------------------------------------------------------
  // The id_mem and diag_mem contents survive reset, as the nonvolatile store would
  logic [7:0]  id_mem   [256];
  logic [7:0]  diag_mem [256];
  logic [79:0] mon_snap_r;
  logic [7:0]  ctrl_stat;
  logic [7:0]  rd_byte;
  logic        page_r;
  logic [7:0]  ptr_r;

  always_comb begin
    ctrl_stat = 8'h00;
    ctrl_stat[`OXCVR_CS_HW_DIS_BIT] = hw_dis_q;
    ctrl_stat[`OXCVR_CS_SW_DIS_BIT] = sw_dis_r;
    ctrl_stat[`OXCVR_CS_FAULT_BIT]  = fault_r;
    ctrl_stat[`OXCVR_CS_LOS_BIT]    = los_q;
  end

  always_comb begin
    rd_byte = 8'h00;
    if (!page_r) begin
      rd_byte = id_mem[ptr_r];
    end else if (ptr_r == `OXCVR_CTRL_STAT_OFS) begin
      rd_byte = ctrl_stat;
    end else if (ptr_r >= `OXCVR_MON_FIRST_OFS && ptr_r <= `OXCVR_MON_LAST_OFS) begin
      rd_byte = mon_snap_r[8'(79 - 8 * (ptr_r - `OXCVR_MON_FIRST_OFS)) -: 8];
    end else begin
      rd_byte = diag_mem[ptr_r];
    end
  end

  chk_los_mirror: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    optical_input_lost_o == $past(ctrl_stat[`OXCVR_CS_LOS_BIT])) else $error("los mirror");

  // ---------------------------------------------------------------
  // EEPROM-style slave
  // ---------------------------------------------------------------
  oxcvr_state_t st_r;
  logic [3:0]   cnt_r;
  logic [7:0]   shift_r;
  logic [7:0]   out_r;
  logic         rw_r;
  logic         drive_low_r;
  logic         addr_hit;
  logic         wr_strobe;

  assign addr_hit  = (shift_r[7:1] == `OXCVR_DEV_ID_PAGE) ||
                     (shift_r[7:1] == `OXCVR_DEV_DIAG_PAGE);
  assign wr_strobe = scl_fall && st_r == OX_WRITE && cnt_r == 4'h8;
  assign sda_o     = 1'b0;
  assign sda_oe_o  = drive_low_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      st_r        <= OX_IDLE;
      cnt_r       <= 4'h0;
      shift_r     <= 8'h00;
      out_r       <= 8'h00;
      rw_r        <= 1'b0;
      page_r      <= 1'b0;
      ptr_r       <= 8'h00;
      drive_low_r <= 1'b0;
    end else if (bus_start) begin
      st_r        <= OX_ADDR;
      cnt_r       <= 4'h0;
      drive_low_r <= 1'b0;
    end else if (bus_stop) begin
      st_r        <= OX_IDLE;
      drive_low_r <= 1'b0;
    end else if (scl_rise) begin
      if (st_r == OX_HOST_ACK) begin
        if (sda_q) begin
          st_r <= OX_IDLE;
        end
      end else if (st_r != OX_IDLE) begin
        shift_r <= {shift_r[6:0], sda_q};
        cnt_r   <= 4'(cnt_r + 4'h1);
      end
    end else if (scl_fall) begin
      unique case (st_r)
        OX_IDLE: begin
          drive_low_r <= 1'b0;
        end
        OX_ADDR: begin
          if (cnt_r == 4'h8) begin
            if (addr_hit) begin
              page_r      <= shift_r[1];
              rw_r        <= shift_r[0];
              drive_low_r <= 1'b1;
              st_r        <= OX_ACK_ADDR;
            end else begin
              st_r <= OX_IDLE;
            end
          end
        end
        OX_ACK_ADDR: begin
          cnt_r <= 4'h0;
          if (rw_r) begin
            out_r       <= rd_byte;
            drive_low_r <= ~rd_byte[7];
            ptr_r       <= 8'(ptr_r + 8'h01);
            st_r        <= OX_READ;
          end else begin
            drive_low_r <= 1'b0;
            st_r        <= OX_OFFSET;
          end
        end
        OX_OFFSET: begin
          if (cnt_r == 4'h8) begin
            ptr_r       <= shift_r;
            drive_low_r <= 1'b1;
            st_r        <= OX_ACK_OFS;
          end
        end
        OX_ACK_OFS, OX_ACK_WR: begin
          drive_low_r <= 1'b0;
          cnt_r       <= 4'h0;
          st_r        <= OX_WRITE;
        end
        OX_WRITE: begin
          if (cnt_r == 4'h8) begin
            ptr_r       <= 8'(ptr_r + 8'h01);
            drive_low_r <= 1'b1;
            st_r        <= OX_ACK_WR;
          end
        end
        OX_READ: begin
          if (cnt_r == 4'h8) begin
            drive_low_r <= 1'b0;
            st_r        <= OX_HOST_ACK;
          end else begin
            drive_low_r <= ~out_r[3'(4'h7 - cnt_r)];
          end
        end
        OX_HOST_ACK: begin
          cnt_r       <= 4'h0;
          out_r       <= rd_byte;
          drive_low_r <= ~rd_byte[7];
          ptr_r       <= 8'(ptr_r + 8'h01);
          st_r        <= OX_READ;
        end
      endcase
    end
  end

  // Monitors are frozen at the address byte so a multi-byte read is coherent
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      mon_snap_r <= 80'h0;
    end else if (scl_fall && st_r == OX_ADDR && cnt_r == 4'h8) begin
      mon_snap_r <= {mon_temp_i, mon_vcc_i, mon_bias_i, mon_txpwr_i, mon_rxpwr_i};
    end
  end

  // Monitor bytes and the shutdown state bit are read-only
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sw_dis_r <= `OXCVR_SW_DIS_RST;
    end else if (wr_strobe && page_r && ptr_r == `OXCVR_CTRL_STAT_OFS) begin
      sw_dis_r <= shift_r[`OXCVR_CS_SW_DIS_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_strobe) begin
      if (!page_r) begin
        id_mem[ptr_r] <= shift_r;
      end else if (ptr_r != `OXCVR_CTRL_STAT_OFS &&
                   (ptr_r < `OXCVR_MON_FIRST_OFS || ptr_r > `OXCVR_MON_LAST_OFS)) begin
        diag_mem[ptr_r] <= shift_r;
      end
    end
  end

  chk_addr_miss: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    scl_fall && st_r == OX_ADDR && cnt_r == 4'h8 && !addr_hit && !bus_start && !bus_stop
    |=> st_r == OX_IDLE && !sda_oe_o) else $error("foreign address acknowledged");
  chk_addr_ack: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    st_r == OX_ACK_ADDR |-> sda_oe_o) else $error("address not acknowledged");

endmodule : oxcvr_mgmt

// ---- oxcvr_regs.svh ----
// Register offsets, field positions and reset values of the transceiver management block
`ifndef OXCVR_REGS_SVH
`define OXCVR_REGS_SVH

// -----------------------------------------------------------------
// Serial device addresses (7-bit form of 0xA0 and 0xA2)
// -----------------------------------------------------------------
`define OXCVR_DEV_ID_PAGE    7'h50
`define OXCVR_DEV_DIAG_PAGE  7'h51

// -----------------------------------------------------------------
// Diagnostics page layout
// -----------------------------------------------------------------
`define OXCVR_CTRL_STAT_OFS  8'h6e
`define OXCVR_MON_FIRST_OFS  8'h60
`define OXCVR_MON_LAST_OFS   8'h69
`define OXCVR_MON_TEMP_OFS   8'h60
`define OXCVR_MON_VCC_OFS    8'h62
`define OXCVR_MON_BIAS_OFS   8'h64
`define OXCVR_MON_TXPWR_OFS  8'h66
`define OXCVR_MON_RXPWR_OFS  8'h68

// -----------------------------------------------------------------
// Control and status byte fields
// -----------------------------------------------------------------
`define OXCVR_CS_HW_DIS_BIT  7
`define OXCVR_CS_SW_DIS_BIT  6
`define OXCVR_CS_FAULT_BIT   2
`define OXCVR_CS_LOS_BIT     1

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define OXCVR_SW_DIS_RST     1'b0
`define OXCVR_HW_DIS_RST     1'b1
`define OXCVR_PIN_LOW_RST    1'b0
`define OXCVR_IDLE_HIGH_RST  1'b1

`endif

// ---- oxcvr_pkg.sv ----
// Types shared by the transceiver management block
package oxcvr_pkg;

  typedef enum logic [3:0] {
    OX_IDLE,
    OX_ADDR,
    OX_ACK_ADDR,
    OX_OFFSET,
    OX_ACK_OFS,
    OX_WRITE,
    OX_ACK_WR,
    OX_READ,
    OX_HOST_ACK
  } oxcvr_state_t;

endpackage : oxcvr_pkg

// ---- oxcvr_pin_sync.sv ----
// Three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ns
module oxcvr_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Single-sample disagreements are treated as glitches and held off
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      level_o <= RST_VAL;
    end else if (s2_r == s3_r) begin
      level_o <= s3_r;
    end
  end

endmodule : oxcvr_pin_sync

// ---- oxcvr_host_model.sv ----
// Host board model: bit-banged master on the two-wire management bus
`timescale 1ns/1ns
module oxcvr_host_model (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ------------------------------
  // Bus phases
  // ------------------------------
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Ten clocks a phase: above the 4-clock pin sync delay and the edge detect behind it
  task automatic gap();
    repeat (10) @(posedge ref_clk_i);
    #1;
  endtask : gap

  // SDA moves only mid-way through SCL low, never beside an SCL edge
  task automatic bit_io(input logic b, output logic s);
    gap();
    sda_low_o = !b;
    gap();
    scl_o = 1'b1;
    gap();
    s = sda_i;
    gap();
    scl_o = 1'b0;
  endtask : bit_io

  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic s9);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, s9);
  endtask : xfer

  // Also a repeated start: SDA is released while SCL is still low
  task automatic start();
    gap();
    sda_low_o = 1'b0;
    gap();
    scl_o = 1'b1;
    gap();
    sda_low_o = 1'b1;
    gap();
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    gap();
    sda_low_o = 1'b1;
    gap();
    scl_o = 1'b1;
    gap();
    sda_low_o = 1'b0;
    gap();
  endtask : stop
endmodule : oxcvr_host_model

// ---- test_oxcvr_mgmt.sv ----
// Self-checking bench for the transceiver management block
`timescale 1ns/1ns
module test_oxcvr_mgmt;
  logic        ref_clk_i            = 1'b0;
  logic        rstn_i               = 1'b0;
  logic        tx_rate_i            = 1'b0;
  logic        rx_rate_i            = 1'b0;
  logic        tx_disable_i         = 1'b1;
  logic        laser_fault_i        = 1'b0;
  logic        optical_input_lost_i = 1'b0;
  logic [15:0] mon [5]              = '{default: 16'h0000};
  logic        scl;
  logic        host_low;
  logic        sda_o;
  logic        sda_oe_o;
  logic        tx_cdr_engage_o;
  logic        rx_cdr_engage_o;
  logic        laser_on_o;
  logic        tx_fault_o;
  logic        tx_path_reset_o;
  logic        optical_input_lost_o;
  logic [7:0]  q;
  logic        a;
  logic [31:0] r;
  logic [7:0]  rd_q [$];
  logic [31:0] seed                 = 32'h0000_2dd4;
  int          miscompares          = 0;
  int          checks_done          = 0;
  int          pulses               = 0;
  // Open-drain data wire with the board pull-up
  wire         sda = !(host_low || (sda_oe_o && !sda_o));

  oxcvr_mgmt uut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .tx_rate_i(tx_rate_i), .rx_rate_i(rx_rate_i),
    .tx_disable_i(tx_disable_i), .laser_fault_i(laser_fault_i),
    .optical_input_lost_i(optical_input_lost_i), .mon_temp_i(mon[0]), .mon_vcc_i(mon[1]),
    .mon_bias_i(mon[2]), .mon_txpwr_i(mon[3]), .mon_rxpwr_i(mon[4]), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .tx_cdr_engage_o(tx_cdr_engage_o),
    .rx_cdr_engage_o(rx_cdr_engage_o), .laser_on_o(laser_on_o), .tx_fault_o(tx_fault_o),
    .tx_path_reset_o(tx_path_reset_o), .optical_input_lost_o(optical_input_lost_o)
  );

  oxcvr_host_model host (
    .ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low)
  );

  // ------------------------------
  // Helpers
  // ------------------------------
  always #50 ref_clk_i = !ref_clk_i;

  always @(posedge ref_clk_i) begin
    if (tx_path_reset_o === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function logic [7:0] cs_exp(input logic hw, input logic sw, input logic flt, input logic los);
    return {hw, sw, 3'b000, flt, los, 1'b0};
  endfunction : cs_exp

  function logic [7:0] mon_exp(input int k);
    return k[0] ? mon[k / 2][7:0] : mon[k / 2][15:8];
  endfunction : mon_exp

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic addr_ofs(input logic [7:0] dev, input logic [7:0] ofs);
    host.start();
    host.xfer(dev, 1'b1, q, a);
    check("ack_dev", a, 1'b0);
    host.xfer(ofs, 1'b1, q, a);
    check("ack_ofs", a, 1'b0);
  endtask : addr_ofs

  task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [15:0] d,
                    input int n);
    addr_ofs(dev, ofs);
    for (int i = 0; i < n; i++) begin
      host.xfer(d[15 - 8 * i -: 8], 1'b1, q, a);
      check("ack_data", a, 1'b0);
    end
    host.stop();
  endtask : wr

  // Random read: offset written, then repeated start; last byte gets no ack
  task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, input int n);
    addr_ofs(dev, ofs);
    host.start();
    host.xfer(dev | 8'h01, 1'b1, q, a);
    check("ack_rd", a, 1'b0);
    rd_q.delete();
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hff, i == n - 1, q, a);
      rd_q.push_back(q);
    end
    host.stop();
  endtask : rd

  task automatic end_sim();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    tick(8);
    check("sda_oe_rst", sda_oe_o, 1'b0);
    rstn_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      tx_rate_i = r[0];
      rx_rate_i = r[1];
      mon[i % 5] = r[31:16];
      tick(8);
      check("tx_cdr", tx_cdr_engage_o, r[0]);
      check("rx_cdr", rx_cdr_engage_o, r[1]);
    end
    // Opposite settings on the two sides, then both swapped
    tx_rate_i = 1'b0;
    rx_rate_i = 1'b1;
    tick(8);
    check("tx_cdr_low", tx_cdr_engage_o, 1'b0);
    check("rx_cdr_high", rx_cdr_engage_o, 1'b1);
    tx_rate_i = 1'b1;
    rx_rate_i = 1'b0;
    tick(8);
    check("tx_cdr_up", tx_cdr_engage_o, 1'b1);
    check("rx_cdr_down", rx_cdr_engage_o, 1'b0);
    check("laser_dflt", laser_on_o, 1'b0);
    tx_disable_i = 1'b0;
    tick(10);
    check("laser_on", laser_on_o, 1'b1);
    check("path_reset", pulses[15:0], 16'h0001);
    optical_input_lost_i = 1'b1;
    tick(8);
    check("los", optical_input_lost_o, 1'b1);
    wr(8'ha2, 8'h6e, 16'hff00, 1);
    tick(8);
    check("laser_sw", laser_on_o, 1'b0);
    rd(8'ha2, 8'h6e, 1);
    check("cs_sw", rd_q[0], cs_exp(0, 1, 0, 1));
    wr(8'ha2, 8'h6e, 16'h0000, 1);
    tick(8);
    check("laser_sw_off", laser_on_o, 1'b1);
    laser_fault_i = 1'b1;
    tick(8);
    check("fault_set", tx_fault_o, 1'b1);
    check("laser_flt", laser_on_o, 1'b0);
    laser_fault_i = 1'b0;
    tick(8);
    rd(8'ha2, 8'h6e, 1);
    check("cs_flt", rd_q[0], cs_exp(0, 0, 1, 1));
    // First shutdown assertion by the host, so no spacing to keep yet
    tx_disable_i = 1'b1;
    tick(8);
    check("laser_hw", laser_on_o, 1'b0);
    rd(8'ha2, 8'h6e, 1);
    check("cs_hw", rd_q[0], cs_exp(1, 0, 1, 1));
    tx_disable_i = 1'b0;
    tick(10);
    check("fault_clr", tx_fault_o, 1'b0);
    check("laser_back", laser_on_o, 1'b1);
    check("path_reset2", pulses[15:0], 16'h0002);
    // Fresh monitor values must show in the next read
    r = rnd();
    mon[2] = r[15:0];
    mon[4] = r[31:16];
    rd(8'ha2, 8'h60, 10);
    for (int k = 0; k < 10; k++) begin
      check("monitor", rd_q[k], mon_exp(k));
    end
    r = rnd();
    wr(8'ha0, 8'hff, r[15:0], 2);
    rd(8'ha0, 8'hff, 2);
    check("id_wrap", {rd_q[0], rd_q[1]}, r[15:0]);
    host.start();
    host.xfer(8'ha4, 1'b1, q, a);
    check("nack_dev", a, 1'b1);
    host.stop();
    end_sim();
  end

  // About 16000 cycles of traffic; two and a half times that means a hang
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    miscompares++;
    end_sim();
  end
endmodule : test_oxcvr_mgmt
